//--- hdl/tmc_timer.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
`include "tmc_defines.svh"

module tmc_timer (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EXT_CLK,
    input wire logic FIX_CLK,
    input wire logic DEBUG_ACTIVE,
    output logic IRQ,
    output logic CENTER_ALIGN,
    output logic [15:0] COUNT,
    output logic PIN_OWN,
    output logic PULLUP_EN
);

    // Mask of prescaler bits that must be all ones.
    function automatic logic [6:0] ps_mask(
        input logic [2:0] ps
    );
        logic [7:0] m;
        m = 8'h00;
        m = (8'h01 << ps) - 8'h01;
        return m[6:0];
    endfunction

    tmc_pkg::tmc_sc_t sc_q;
    tmc_pkg::tmc_dir_t dir_q;
    logic [15:0] cnt_q;
    logic [15:0] mod_q;
    logic [15:0] buf_q;
    logic [15:0] snap_q;
    logic lock_q;
    logic lock_hi_q;
    logic armed_q;
    logic mod_wait_q;
    logic mod_hi_q;
    logic [6:0] psc_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic fix_s1_q;
    logic fix_s2_q;
    logic fix_s3_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic irq_q;
    logic own_q;

    // Bus decode; an access completes on the edge where PREADY is high.
    wire acc = PSEL && PENABLE;
    wire done = acc && pready_q;
    wire wr = done && PWRITE;
    wire rd = done && !PWRITE;
    wire a_sc = PADDR == `TMC_OFS_SC;
    wire a_ch = PADDR == `TMC_OFS_CNTH;
    wire a_cl = PADDR == `TMC_OFS_CNTL;
    wire a_mh = PADDR == `TMC_OFS_MODH;
    wire a_ml = PADDR == `TMC_OFS_MODL;
    wire mapped = a_sc || a_ch || a_cl || a_mh || a_ml;
    wire wr_sc = wr && a_sc;
    wire wr_cnt = wr && (a_ch || a_cl);
    wire wr_mod = wr && (a_mh || a_ml);
    wire rd_sc = rd && a_sc;
    wire rd_cnt = rd && (a_ch || a_cl);

    // Source tick selection after synchronization.
    wire ext_rise = ext_s2_q && !ext_s3_q;
    wire fix_rise = fix_s2_q && !fix_s3_q;
    logic src_tick;
    always_comb
    begin
        case (sc_q.src)
            // [RL12] source field decode
            tmc_pkg::TMC_CS_BUS: src_tick = 1'b1;
            tmc_pkg::TMC_CS_FIX: src_tick = fix_rise;
            // [RL2] external clock path
            tmc_pkg::TMC_CS_EXT: src_tick = ext_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // [RL13] power-of-two divide
    wire [6:0] msk = ps_mask(sc_q.ps);
    wire pre_tick = src_tick && ((psc_q & msk) == msk);

    // [RL21] gated step enable
    wire step = pre_tick && !DEBUG_ACTIVE;

    // [RL19] free-running limit
    wire full = mod_q == 16'h0000 || mod_q == `TMC_CNT_FULL;
    wire [15:0] top = full ? `TMC_CNT_FULL : mod_q;
    wire at_top = cnt_q == top;

    // Next count, direction and overflow event.
    logic [15:0] cnt_d;
    tmc_pkg::tmc_dir_t dir_d;
    logic ovf;
    always_comb
    begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        ovf = 1'b0;
        if (wr_cnt)
        begin
            // [RL17] write clears count
            cnt_d = `TMC_CNT_RST;
            dir_d = tmc_pkg::TMC_UP;
        end
        else if (step && !sc_q.center_align_select)
        begin
            // [RL18] up mode wraps
            cnt_d = at_top ? 16'h0000 : cnt_q + 16'h0001;
            dir_d = tmc_pkg::TMC_UP;
            // [RL6] up overflow
            ovf = at_top;
        end
        else if (step)
        begin
            case (dir_q)
                tmc_pkg::TMC_UP:
                begin
                    // [RL11] up/down counting
                    if (at_top)
                    begin
                        cnt_d = cnt_q - 16'h0001;
                        dir_d = tmc_pkg::TMC_DN;
                        // [RL7] center overflow
                        ovf = 1'b1;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end
                tmc_pkg::TMC_DN:
                begin
                    if (cnt_q == 16'h0000)
                    begin
                        cnt_d = 16'h0001;
                        dir_d = tmc_pkg::TMC_UP;
                    end
                    else
                    begin
                        cnt_d = cnt_q - 16'h0001;
                    end
                end
                default: dir_d = tmc_pkg::TMC_UP;
            endcase
        end
    end

    // Overflow is held off while a modulo write is half done.
    wire ovf_ok = ovf && !mod_wait_q;

    // [RL8] read-then-write-zero clear
    wire tof_clr = wr_sc && armed_q && !PWDATA[`TMC_BIT_TOF];
    wire tof_d = ovf_ok || (sc_q.overflow_flag && !tof_clr);
    // [RL9] new overflow restarts
    wire armed_d = !ovf_ok && !wr_sc && (armed_q || (rd_sc && sc_q.overflow_flag));

    // [RL14] coherent byte latch
    wire rd_now = rd_cnt && !DEBUG_ACTIVE;
    wire [15:0] cview = lock_q ? buf_q : cnt_q;
    // [RL15] restart on writes
    wire lock_rst = wr_cnt || wr_sc;
    wire lock_d = lock_rst ? 1'b0 : (rd_now ? (!lock_q || lock_hi_q == a_ch) : lock_q);

    // Read data mux; count bytes are read-only.
    logic [7:0] rbyte;
    always_comb
    begin
        rbyte = 8'h00;
        if (a_sc)
            rbyte = sc_q;
        else if (a_ch)
            rbyte = cview[15:8];
        else if (a_cl)
            rbyte = cview[7:0];
        else if (a_mh)
            rbyte = mod_q[15:8];
        else if (a_ml)
            rbyte = mod_q[7:0];
    end

    // Synchronizers for the sampled clock pins.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            fix_s1_q <= 1'b0;
            fix_s2_q <= 1'b0;
            fix_s3_q <= 1'b0;
        end
        else
        begin
            ext_s1_q <= EXT_CLK;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            fix_s1_q <= FIX_CLK;
            fix_s2_q <= fix_s1_q;
            fix_s3_q <= fix_s2_q;
        end
    end

    // APB handshake with one wait state.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= acc && !pready_q;
            pslverr_q <= acc && !pready_q && !mapped;
            prdata_q <= (acc && !pready_q && !PWRITE) ? {24'h000000, rbyte} : 32'h00000000;
        end
    end

    // Status register, prescaler and counter.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // [RL1] reset disabled
            sc_q <= `TMC_SC_RST;
            // [RL16] count clears
            cnt_q <= `TMC_CNT_RST;
            dir_q <= tmc_pkg::TMC_UP;
            psc_q <= 7'h00;
            armed_q <= 1'b0;
        end
        else
        begin
            sc_q.overflow_flag <= tof_d;
            if (wr_sc)
                sc_q[6:0] <= PWDATA[6:0];
            psc_q <= (sc_q.src == tmc_pkg::TMC_CS_OFF) ? 7'h00 : psc_q + {6'h00, src_tick};
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            armed_q <= armed_d;
        end
    end

    // Modulo register with write pairing.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            mod_q <= `TMC_MOD_RST;
            mod_wait_q <= 1'b0;
            mod_hi_q <= 1'b0;
        end
        else if (wr_mod)
        begin
            if (a_mh)
                mod_q[15:8] <= PWDATA[7:0];
            else
                mod_q[7:0] <= PWDATA[7:0];
            mod_wait_q <= !mod_wait_q || mod_hi_q == a_mh;
            mod_hi_q <= a_mh;
        end
    end

    // Coherency latch; the snapshot holds the count that the read data was built from.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            buf_q <= `TMC_CNT_RST;
            snap_q <= `TMC_CNT_RST;
            lock_q <= 1'b0;
            lock_hi_q <= 1'b0;
        end
        else
        begin
            if (acc && !pready_q)
                snap_q <= cnt_q;
            // [RL20] debug freezes latch
            if (rd_now && !lock_q && !lock_rst)
            begin
                buf_q <= snap_q;
                lock_hi_q <= a_ch;
            end
            lock_q <= lock_d;
        end
    end

    // Registered pin-side outputs.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            irq_q <= 1'b0;
            own_q <= 1'b0;
        end
        else
        begin
            // [RL10] interrupt request
            irq_q <= tof_d && (wr_sc ? PWDATA[`TMC_BIT_OVERFLOW_IRQ_ENABLE] : sc_q.overflow_irq_enable);
            // [RL5] timer owns clock pin
            own_q <= wr_sc ? PWDATA[4:3] == 2'b11 : sc_q.src == tmc_pkg::TMC_CS_EXT;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign IRQ = irq_q;
    assign CENTER_ALIGN = sc_q.center_align_select;
    assign COUNT = cnt_q;
    assign PIN_OWN = own_q;
    assign PULLUP_EN = own_q;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    chk_ovf_sets_flag: assert property (ovf_ok |=> sc_q.overflow_flag) // [RL6]
        else $error("overflow did not set flag");
    chk_up_wrap_zero: assert property (step && !sc_q.center_align_select && at_top && !wr_cnt |=> cnt_q == 16'h0000) // [RL18]
        else $error("up wrap not zero");
    chk_center_down: assert property (step && sc_q.center_align_select && dir_q == tmc_pkg::TMC_UP && at_top && !wr_cnt
        |=> dir_q == tmc_pkg::TMC_DN && sc_q.overflow_flag == !mod_wait_q || $past(mod_wait_q)) // [RL7]
        else $error("center turn wrong");
    chk_tof_one_noeff: assert property (sc_q.overflow_flag && wr_sc && PWDATA[7] |=> sc_q.overflow_flag) // [RL8]
        else $error("write one cleared flag");
    chk_tof_noread: assert property (sc_q.overflow_flag && !armed_q && !ovf_ok |=> sc_q.overflow_flag) // [RL8]
        else $error("flag cleared without read");
    chk_set_wins: assert property (ovf_ok && tof_clr |=> sc_q.overflow_flag && !armed_q) // [RL9]
        else $error("clear beat new overflow");
    chk_irq_level: assert property (IRQ == (sc_q.overflow_flag && sc_q.overflow_irq_enable)) // [RL10]
        else $error("irq mismatch");
    chk_no_src_still: assert property (sc_q.src == tmc_pkg::TMC_CS_OFF && !wr_cnt |=> $stable(cnt_q)) // [RL21]
        else $error("count moved without source");
    chk_debug_freeze: assert property (DEBUG_ACTIVE && !wr_cnt && !lock_rst
        |=> $stable(cnt_q) && $stable(lock_q)) // [RL20]
        else $error("debug did not freeze");
    chk_cnt_write: assert property (wr_cnt |=> cnt_q == 16'h0000) // [RL17]
        else $error("count write did not clear");
    chk_latch_hold: assert property (lock_q && !lock_rst && !(rd_now && lock_hi_q != a_ch)
        |=> lock_q && $stable(buf_q)) // [RL14]
        else $error("latch lost early");
    chk_lock_restart: assert property (lock_rst |=> !lock_q) // [RL15]
        else $error("latch not restarted");

    cov_up_overflow: cover property (ovf_ok && !sc_q.center_align_select);
    cov_center_overflow: cover property (ovf_ok && sc_q.center_align_select);
    cov_tof_cleared: cover property (tof_clr && !ovf_ok);
    cov_coherent_pair: cover property (rd_now && lock_q && lock_hi_q != a_ch);

endmodule

//--- hdl/tmc_defines.svh
// Contract
// [RL1] After reset the timer is disabled; its pins are inputs, pullups off.
// [RL2] Source 1:1 clocks the prescaler from the synchronized external pin clock.
// [RL3] The external clock stays at or below a quarter of the bus rate.
// [RL4] Software sets the shared channel's edge/level bits to 0:0.
// [RL5] While the timer owns a pin, port data and direction do not affect it.
// [RL6] Up mode sets the overflow flag, bit 7, when the count rolls to zero.
// [RL7] Center mode sets the overflow flag when stepping down from the modulo.
// [RL8] Overflow flag clears by status read while set, then writing 0.
// [RL9] An overflow between that read and write restarts the clear sequence.
// [RL10] Interrupt request is flag and enable, bit 6; reset clears the enable.
// [RL11] Center-align select, bit 5, makes the counter count up and down.
// [RL12] Bits 4:3 pick off, bus clock, fixed clock or external pin clock.
// [RL13] Bits 2:0 divide the synchronized source clock by two to the field.
// [RL14] Reading either count byte latches both until the other is read.
// [RL15] Reset, count writes and status writes restart the read latch.
// [RL16] Count bytes are read-only views; reset clears the count.
// [RL17] Any write to either count byte clears the counter.
// [RL18] Past the modulo, up mode returns to zero; center mode counts down.
// [RL19] Modulo of zero or all ones makes the counter free-running.
// [RL20] Debug mode freezes the counter and the read latch.
// [RL21] The counter steps once per prescaler pulse and never with no source.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
`define TMC_OFS_SC 8'h00
`define TMC_OFS_CNTH 8'h04
`define TMC_OFS_CNTL 8'h08
`define TMC_OFS_MODH 8'h0c
`define TMC_OFS_MODL 8'h10
`define TMC_BIT_TOF 7
`define TMC_BIT_OVERFLOW_IRQ_ENABLE 6
`define TMC_BIT_CENTER_ALIGN_SELECT 5
`define TMC_SC_RST 8'h00
`define TMC_CNT_RST 16'h0000
`define TMC_MOD_RST 16'h0000
`define TMC_CNT_FULL 16'hffff
`endif

//--- hdl/tmc_pkg.sv
package tmc_pkg;

    // Clock source codes of the status register.
    typedef enum logic [1:0] {
        TMC_CS_OFF = 2'b00,
        TMC_CS_BUS = 2'b01,
        TMC_CS_FIX = 2'b10,
        TMC_CS_EXT = 2'b11
    } tmc_src_t;

    // Counting direction of the counter.
    typedef enum logic {
        TMC_UP = 1'b0,
        TMC_DN = 1'b1
    } tmc_dir_t;

    // Status and control register layout.
    typedef struct packed {
        logic overflow_flag;
        logic overflow_irq_enable;
        logic center_align_select;
        tmc_src_t src;
        logic [2:0] ps;
    } tmc_sc_t;

endpackage

//--- test/tb.sv
`timescale 1ns/10ps
`include "tmc_defines.svh"

module tb;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic EXT_CLK = 1'b0;
    logic FIX_CLK = 1'b0;
    logic DEBUG_ACTIVE = 1'b0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic IRQ;
    logic CENTER_ALIGN;
    logic [15:0] COUNT;
    logic PIN_OWN;
    logic PULLUP_EN;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;
    logic [15:0] n;
    logic [15:0] c0;
    logic [15:0] mx;
    logic down;

    tmc_timer i_dut (
        .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .EXT_CLK(EXT_CLK), .FIX_CLK(FIX_CLK), .DEBUG_ACTIVE(DEBUG_ACTIVE), .IRQ(IRQ),
        .CENTER_ALIGN(CENTER_ALIGN), .COUNT(COUNT), .PIN_OWN(PIN_OWN), .PULLUP_EN(PULLUP_EN)
    );

    // Bus clock with a 40 ns period.
    initial
    begin
        forever #20 CLK = ~CLK;
    end

    // Prints the verdict and ends the run.
    task automatic give_verdict;
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Compares one observed value with its expectation.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer, held until PREADY is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do
        begin
            @(posedge CLK);
            k++;
        end
        while (PREADY !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            err_count++;
            $display("mismatch at %0t: bus transfer timed out", $time);
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // Reads a register and compares it.
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp, what);
    endtask

    // Slow clock pulses on the external or fixed pin, an eighth of the bus rate.
    // below quarter rate
    // pin only clocks, no channel drives it
    task automatic pulse(input logic fix, input int cnt);
        repeat (cnt)
        begin
            @(posedge CLK);
            if (fix)
                FIX_CLK <= 1'b1;
            else
                EXT_CLK <= 1'b1;
            repeat (4) @(posedge CLK);
            FIX_CLK <= 1'b0;
            EXT_CLK <= 1'b0;
            repeat (3) @(posedge CLK);
        end
        repeat (8) @(posedge CLK);
    endtask

    // Waits a bounded time for the interrupt request.
    task automatic wait_irq;
        int k;
        k = 0;
        while (IRQ !== 1'b1 && k < 3000)
        begin
            @(posedge CLK);
            k++;
        end
        if (k >= 3000)
        begin
            err_count++;
            $display("mismatch at %0t: interrupt wait timed out", $time);
        end
    endtask

    // Cuts a hung run short.
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_count++;
            give_verdict();
        end
    end

    // Main sequence.
    initial
    begin
        void'($urandom(98143));
        repeat (4) @(posedge CLK);
        RESET_N <= 1'b1;
        chk(32'({IRQ, CENTER_ALIGN, PIN_OWN, PULLUP_EN, COUNT}), 32'h0, "reset outputs");
        rchk(`TMC_OFS_SC, 32'h00, "sc reset");
        rchk(`TMC_OFS_CNTH, 32'h00, "cnth reset");
        rchk(`TMC_OFS_CNTL, 32'h00, "cntl reset");
        apb(1'b0, 8'h20, 32'h0);
        chk(32'({er, rd[30:0]}), 32'h8000_0000, "unmapped read");
        for (int p = 0; p < 8; p++)
        begin
            apb(1'b1, `TMC_OFS_SC, 32'(8 + p));
            repeat (8) @(posedge CLK);
            c0 = COUNT;
            repeat (256) @(posedge CLK);
            chk(32'(COUNT - c0), 32'(256 >> p), "prescale steps");
        end
        apb(1'b1, `TMC_OFS_SC, 32'h00);
        c0 = COUNT;
        repeat (40) @(posedge CLK);
        chk(32'(COUNT), 32'(c0), "no source");
        apb(1'b1, `TMC_OFS_CNTL, 32'(1 + $urandom % 255));
        rchk(`TMC_OFS_CNTL, 32'h00, "count write");
        rchk(`TMC_OFS_CNTH, 32'h00, "count high");
        apb(1'b1, `TMC_OFS_SC, 32'h18);
        n = 16'(250 + $urandom % 6);
        pulse(1'b0, n);
        chk(32'({PIN_OWN, PULLUP_EN}), 32'h3, "pin owned");
        rchk(`TMC_OFS_CNTL, 32'(n[7:0]), "ext count low");
        pulse(1'b0, 10);
        rchk(`TMC_OFS_CNTH, 32'(n[15:8]), "latched high");
        n = n + 16'h000a;
        rchk(`TMC_OFS_CNTL, 32'(n[7:0]), "new latch");
        apb(1'b1, `TMC_OFS_SC, 32'h18);
        pulse(1'b0, 2);
        n = n + 16'h0002;
        rchk(`TMC_OFS_CNTL, 32'(n[7:0]), "latch restart");
        rchk(`TMC_OFS_CNTH, 32'(n[15:8]), "release high");
        DEBUG_ACTIVE <= 1'b1;
        pulse(1'b0, 3);
        chk(32'(COUNT), 32'(n), "debug freeze");
        DEBUG_ACTIVE <= 1'b0;
        pulse(1'b0, 1);
        chk(32'(COUNT), 32'(n + 16'h0001), "ext step");
        apb(1'b1, `TMC_OFS_SC, 32'h10);
        pulse(1'b0, 3);
        chk(32'({PIN_OWN, PULLUP_EN, COUNT}), 32'(n + 16'h0001), "fixed ignores ext");
        pulse(1'b1, 5);
        chk(32'(COUNT), 32'(n + 16'h0006), "fixed steps");
        apb(1'b1, `TMC_OFS_CNTH, 32'($urandom % 256));
        @(posedge CLK);
        chk(32'(COUNT), 32'h0, "running clear");
        apb(1'b1, `TMC_OFS_SC, 32'h00);
        apb(1'b1, `TMC_OFS_MODH, 32'h03);
        apb(1'b1, `TMC_OFS_MODL, 32'($urandom % 256));
        apb(1'b1, `TMC_OFS_CNTL, 32'h00);
        apb(1'b1, `TMC_OFS_SC, 32'h48);
        wait_irq();
        chk(32'({IRQ, COUNT < 16'h0004}), 32'h3, "wrap flag");
        apb(1'b1, `TMC_OFS_SC, 32'h48);
        rchk(`TMC_OFS_SC, 32'hc8, "clear without read");
        apb(1'b1, `TMC_OFS_SC, 32'h48);
        rchk(`TMC_OFS_SC, 32'h48, "flag cleared");
        chk(32'(IRQ), 32'h0, "irq dropped");
        apb(1'b1, `TMC_OFS_SC, 32'hc8);
        rchk(`TMC_OFS_SC, 32'h48, "write one");
        wait_irq();
        rchk(`TMC_OFS_SC, 32'hc8, "flag again");
        repeat (1100) @(posedge CLK);
        apb(1'b1, `TMC_OFS_SC, 32'h48);
        rchk(`TMC_OFS_SC, 32'hc8, "clear restart");
        apb(1'b1, `TMC_OFS_SC, 32'h88);
        repeat (2) @(posedge CLK);
        chk(32'(IRQ), 32'h0, "irq masked");
        rchk(`TMC_OFS_SC, 32'h88, "masked flag");
        apb(1'b1, `TMC_OFS_SC, 32'h00);
        rchk(`TMC_OFS_SC, 32'h00, "off cleared");
        apb(1'b1, `TMC_OFS_MODH, 32'h00);
        apb(1'b1, `TMC_OFS_MODL, 32'h10);
        apb(1'b1, `TMC_OFS_CNTL, 32'h00);
        apb(1'b1, `TMC_OFS_SC, 32'h28);
        mx = 16'h0000;
        down = 1'b0;
        repeat (80)
        begin
            c0 = COUNT;
            @(posedge CLK);
            down = down | (COUNT < c0);
            mx = (COUNT > mx) ? COUNT : mx;
        end
        chk(32'({CENTER_ALIGN, down, mx}), 32'h3_0010, "center sweep");
        rchk(`TMC_OFS_SC, 32'ha8, "center flag");
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        rchk(`TMC_OFS_SC, 32'h00, "second reset");
        chk(32'({CENTER_ALIGN, PIN_OWN, COUNT}), 32'h0, "second reset out");
        give_verdict();
    end
endmodule
